// ===== verilog/vector_irq_pkg.sv
// Constants, register map, states and carriers of the vectored interrupt block.
// Assumes a single system clock and a plain register port driven on that clock.
package vector_irq_pkg;

  localparam int SOURCE_COUNT = 82;
  localparam int VEC_W = 7;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 4;
  localparam int ENTRY_W = 16;

  // Eight instruction words of two bytes each
  localparam logic [ADDR_W-1:0] BASE_RESET = 21'h000008;
  localparam logic [ADDR_W-1:0] LOW_VECTOR_OFFSET = 21'h000010;

  localparam logic [REG_ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_BASE = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_LOCK = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_CAPTURED = 4'h3;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h4;

  localparam int CTRL_PRIO_EN_BIT = 0;
  localparam int CTRL_LOW_EN_BIT = 1;
  localparam int CTRL_HIGH_EN_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int LOCK_BIT = 0;
  localparam int STATUS_FLAG_BIT = 4;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  typedef enum logic [1:0] {
    ST_MAIN = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_HIGH_OVER_LOW = 2'b11
  } isr_state_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage : vector_irq_pkg

// ===== verilog/vector_irq.sv
// Vector address generation, base lock, priority resolution and fetch checks.
// Assumes pending flags arrive already gated by their enables, on clock_in,
// and that the core never asserts take and return in the same cycle.

module vector_irq
  import vector_irq_pkg::*;
#(
  parameter logic [ADDR_W-1:0] PFM_LAST_ADDR = 21'h01ffff,
  parameter logic [ADDR_W-1:0] SAF_FIRST_ADDR = 21'h01ff00
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire reg_req_t reg_req_in,
  output logic [DATA_W-1:0] read_data_out,
  input wire logic [SOURCE_COUNT-1:0] pending_in,
  input wire logic [SOURCE_COUNT-1:0] per_source_priority_bits_in,
  input wire logic multi_vector_select_in,
  input wire logic single_lock_cycle_fuse_in,
  input wire logic storage_flash_enable_in,
  input wire logic take_in,
  input wire logic return_in,
  input wire logic entry_valid_in,
  input wire logic [ENTRY_W-1:0] entry_data_in,
  output logic irq_request_out,
  output logic irq_high_out,
  output logic [VEC_W-1:0] vector_number_out,
  output logic [ADDR_W-1:0] vector_address_out,
  output logic [ADDR_W-1:0] isr_address_out,
  output logic isr_valid_out,
  output logic system_reset_request_out
);

  logic [CTRL_W-1:0] control;
  logic [ADDR_W-1:0] vector_table_base;
  logic base_write_lock_bit;
  logic lock_sealed;
  key_state_t key_state;
  logic [ADDR_W-1:0] captured_vector_address;
  isr_state_t isr_state;
  logic fetch_violation_flag;
  logic await_entry;

  function automatic logic executable(input logic [ADDR_W-1:0] a, input logic saf_en);
    executable = (a <= PFM_LAST_ADDR) && !(saf_en && (a >= SAF_FIRST_ADDR));
  endfunction : executable

  wire priority_levels_enable = control[CTRL_PRIO_EN_BIT];
  wire low_global_enable = control[CTRL_LOW_EN_BIT];
  wire high_global_enable = control[CTRL_HIGH_EN_BIT];

  wire wr_control = reg_req_in.wr && (reg_req_in.addr == REG_CONTROL);
  wire wr_base = reg_req_in.wr && (reg_req_in.addr == REG_BASE);
  wire wr_lock = reg_req_in.wr && (reg_req_in.addr == REG_LOCK);
  wire wr_status = reg_req_in.wr && (reg_req_in.addr == REG_STATUS);
  wire wr_other = reg_req_in.wr && !wr_lock;
  wire [7:0] key_byte = reg_req_in.wdata[7:0];

  // levels off all high
  // With levels off every source counts as high, so in single vector mode all vector to the base
  wire [SOURCE_COUNT-1:0] high_pend = priority_levels_enable ?
    (pending_in & per_source_priority_bits_in) : pending_in;
  wire [SOURCE_COUNT-1:0] low_pend = priority_levels_enable ?
    (pending_in & ~per_source_priority_bits_in) : '0;

  logic [SOURCE_COUNT:0] high_seen;
  logic [SOURCE_COUNT:0] low_seen;
  logic [VEC_W-1:0] high_acc [SOURCE_COUNT+1];
  logic [VEC_W-1:0] low_acc [SOURCE_COUNT+1];

  assign high_seen[0] = 1'b0;
  assign low_seen[0] = 1'b0;
  assign high_acc[0] = '0;
  assign low_acc[0] = '0;

  genvar gi;
  generate
    for (gi = 0; gi < SOURCE_COUNT; gi++) begin : g_order
      wire high_first = high_pend[gi] && !high_seen[gi];
      wire low_first = low_pend[gi] && !low_seen[gi];
      assign high_seen[gi+1] = high_seen[gi] || high_pend[gi];
      assign low_seen[gi+1] = low_seen[gi] || low_pend[gi];
      assign high_acc[gi+1] = high_acc[gi] | (high_first ? VEC_W'(gi) : '0);
      assign low_acc[gi+1] = low_acc[gi] | (low_first ? VEC_W'(gi) : '0);
    end
  endgenerate

  wire high_any = high_seen[SOURCE_COUNT];
  wire low_any = low_seen[SOURCE_COUNT];
  wire state_low_or_main = (isr_state == ST_MAIN) || (isr_state == ST_LOW);

  wire can_high = high_any && high_global_enable && state_low_or_main;
  wire can_low = low_any && low_global_enable && priority_levels_enable &&
    (isr_state == ST_MAIN) && !can_high;

  wire [VEC_W-1:0] sel_number = can_high ? high_acc[SOURCE_COUNT] : low_acc[SOURCE_COUNT];

  wire [ADDR_W-1:0] multi_address = vector_table_base + ADDR_W'({sel_number, 1'b0});
  wire [ADDR_W-1:0] single_address = can_high ? vector_table_base :
    (vector_table_base + LOW_VECTOR_OFFSET);
  wire [ADDR_W-1:0] next_vector = multi_vector_select_in ? multi_address : single_address;
  wire next_request = (can_high || can_low) && !take_in;

  wire accept = take_in && irq_request_out;
  wire entry_bad = accept && !executable(vector_address_out, storage_flash_enable_in);
  wire [ADDR_W-1:0] next_isr = ADDR_W'({entry_data_in, 2'b00});
  wire entry_take = entry_valid_in && await_entry;
  wire isr_bad = entry_take && !executable(next_isr, storage_flash_enable_in);
  wire violation = entry_bad || isr_bad;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_request_out <= 1'b0;
      irq_high_out <= 1'b0;
      vector_number_out <= '0;
      vector_address_out <= '0;
    end else begin
      irq_request_out <= next_request;
      irq_high_out <= can_high;
      vector_number_out <= sel_number;
      vector_address_out <= next_vector;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      captured_vector_address <= '0;
    end else if (accept) begin
      captured_vector_address <= vector_address_out;
    end
  end

  isr_state_t next_state;
  always_comb begin
    next_state = isr_state;
    if (accept) begin
      case (isr_state)
        ST_MAIN: next_state = irq_high_out ? ST_HIGH : ST_LOW;
        ST_LOW: next_state = ST_HIGH_OVER_LOW;
        default: next_state = isr_state;
      endcase
    end else if (return_in) begin
      case (isr_state)
        ST_HIGH_OVER_LOW: next_state = ST_LOW;
        ST_HIGH: next_state = ST_MAIN;
        ST_LOW: next_state = ST_MAIN;
        default: next_state = ST_MAIN;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      isr_state <= ST_MAIN;
    end else begin
      isr_state <= next_state;
    end
  end

  // Only multi vector mode fetches a table entry; single mode jumps in place
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      await_entry <= 1'b0;
      isr_address_out <= '0;
      isr_valid_out <= 1'b0;
      system_reset_request_out <= 1'b0;
    end else begin
      await_entry <= (accept && multi_vector_select_in && !entry_bad) ||
        (await_entry && !entry_valid_in);
      isr_valid_out <= entry_take && !isr_bad;
      if (entry_take) begin
        isr_address_out <= next_isr;
      end
      system_reset_request_out <= violation;
    end
  end

  // flag cleared on violation
  // Held by power-on reset only, so it survives the reset it provokes
  always_ff @(posedge clock_in) begin
    if (por_in) begin
      fetch_violation_flag <= 1'b1;
    end else if (violation) begin
      fetch_violation_flag <= 1'b0;
    end else if (wr_status && reg_req_in.wdata[STATUS_FLAG_BIT]) begin
      fetch_violation_flag <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      control <= CTRL_RESET;
    end else if (wr_control) begin
      control <= reg_req_in.wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      vector_table_base <= BASE_RESET;
    end else if (wr_base && !base_write_lock_bit) begin
      vector_table_base <= reg_req_in.wdata[ADDR_W-1:0];
    end
  end

  // key sequence
  // Key bytes only count with the high global enable clear, so a high ISR cannot split them
  key_state_t next_key;
  always_comb begin
    next_key = KEY_IDLE;
    if (wr_lock && !high_global_enable) begin
      case (key_state)
        KEY_IDLE: next_key = (key_byte == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        KEY_HALF: next_key = (key_byte == KEY_SECOND) ? KEY_ARMED :
          ((key_byte == KEY_FIRST) ? KEY_HALF : KEY_IDLE);
        KEY_ARMED: next_key = KEY_IDLE;
        default: next_key = KEY_IDLE;
      endcase
    end else if (!wr_other && !wr_lock) begin
      next_key = key_state;
    end
  end

  wire lock_write = wr_lock && (key_state == KEY_ARMED) && !high_global_enable;
  wire lock_value = reg_req_in.wdata[LOCK_BIT];
  wire lock_change_ok = lock_write && !(lock_sealed && !lock_value);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      key_state <= KEY_IDLE;
      base_write_lock_bit <= 1'b0;
      lock_sealed <= 1'b0;
    end else begin
      key_state <= next_key;
      if (lock_change_ok) begin
        base_write_lock_bit <= lock_value;
      end
      if (lock_change_ok && lock_value && single_lock_cycle_fuse_in) begin
        lock_sealed <= 1'b1;
      end
    end
  end

  logic [DATA_W-1:0] read_mux;
  always_comb begin
    case (reg_req_in.addr)
      REG_CONTROL: read_mux = DATA_W'(control);
      REG_BASE: read_mux = DATA_W'(vector_table_base);
      REG_LOCK: read_mux = DATA_W'(base_write_lock_bit);
      REG_CAPTURED: read_mux = DATA_W'(captured_vector_address);
      REG_STATUS: read_mux = DATA_W'({fetch_violation_flag, 2'b00, isr_state});
      default: read_mux = '0;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      read_data_out <= '0;
    end else begin
      read_data_out <= reg_req_in.rd ? read_mux : '0;
    end
  end

  a_base_after_reset: assert property (
    @(posedge clock_in) disable iff (rst_in)
    $past(rst_in) |-> (vector_table_base == BASE_RESET))
    else $error("base not at reset value");

  a_single_high_base: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (irq_request_out && irq_high_out && !multi_vector_select_in && !$past(rst_in))
    |-> (vector_address_out == $past(vector_table_base)))
    else $error("high vector differs from base");

  a_single_low_offset: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (irq_request_out && !irq_high_out && !multi_vector_select_in && !$past(rst_in))
    |-> (vector_address_out == $past(vector_table_base) + LOW_VECTOR_OFFSET))
    else $error("low vector offset wrong");

  a_multi_vector_sum: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (irq_request_out && multi_vector_select_in && !$past(rst_in))
    |-> (vector_address_out ==
      $past(vector_table_base) + ADDR_W'({vector_number_out, 1'b0})))
    else $error("multi vector address wrong");

  a_capture_taken: assert property (
    @(posedge clock_in) disable iff (rst_in)
    accept |=> (captured_vector_address == $past(vector_address_out)))
    else $error("vector address not captured");

  a_locked_base_hold: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (wr_base && base_write_lock_bit) |=> $stable(vector_table_base))
    else $error("locked base was written");

  a_lock_needs_key: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (key_state != KEY_ARMED) |=> $stable(base_write_lock_bit))
    else $error("lock changed without key");

  a_sealed_lock_holds: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (lock_sealed && base_write_lock_bit) |=> base_write_lock_bit [*2])
    else $error("sealed lock was cleared");

  a_high_beats_low: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (priority_levels_enable && high_global_enable && state_low_or_main && !take_in &&
      (|(pending_in & per_source_priority_bits_in))) |=> (irq_request_out && irq_high_out))
    else $error("high request not offered first");

  a_levels_off_base: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (!priority_levels_enable && high_global_enable && (|pending_in) && state_low_or_main &&
      !take_in && !multi_vector_select_in)
    |=> (irq_request_out && (vector_address_out == $past(vector_table_base))))
    else $error("levels off vector not at base");

  a_low_resumes: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (isr_state == ST_HIGH_OVER_LOW && return_in && !take_in) |=> (isr_state == ST_LOW))
    else $error("low routine not resumed");

  a_isr_shifted: assert property (
    @(posedge clock_in) disable iff (rst_in)
    entry_take |=> (isr_address_out == ADDR_W'({$past(entry_data_in), 2'b00})))
    else $error("routine address not shifted");

  a_violation_reset: assert property (
    @(posedge clock_in) disable iff (rst_in || por_in)
    entry_bad |=> (system_reset_request_out && !fetch_violation_flag))
    else $error("violation did not request reset");

endmodule : vector_irq

// ===== dv/core_model.sv
// Core stand-in: takes every offered interrupt and, in multi vector mode only, fetches the table entry.
// Assumes the block's one-cycle request latency and a clock shared with it.
module core_model
  import vector_irq_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic irq_request_in,
  input wire logic multi_in,
  input wire logic [ENTRY_W-1:0] entry_in,
  output logic take_out,
  output logic entry_valid_out,
  output logic [ENTRY_W-1:0] entry_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      take_out <= 1'b0;
      entry_valid_out <= 1'b0;
      entry_data_out <= 16'h0000;
      wait_cnt <= 2'h0;
    end else begin
      take_out <= irq_request_in && !take_out;
      entry_valid_out <= (wait_cnt == 2'h1);
      // Lines toggle outside the fetch cycle so a stale entry never matches
      entry_data_out <= (wait_cnt == 2'h1) ? entry_in : ~entry_data_out;
      if (take_out && multi_in) begin
        wait_cnt <= 2'h2;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : core_model

// ===== dv/tb.sv
// Register-level test of the vectored interrupt block with a core stand-in.
// Assumes the block's register map and one-cycle read latency.
module tb
  import vector_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  logic mv = 1'b0;
  logic fuse = 1'b0;
  logic storage_area_flash = 1'b0;
  logic ret = 1'b0;
  reg_req_t req = '0;
  logic [SOURCE_COUNT-1:0] pend = '0;
  logic [SOURCE_COUNT-1:0] prio = '0;
  logic [ENTRY_W-1:0] entry = 16'h1234;
  logic take, ev, irq, irq_hi, isr_v, sreq;
  logic [ENTRY_W-1:0] ed;
  logic [DATA_W-1:0] rdata;
  logic [VEC_W-1:0] vnum;
  logic [ADDR_W-1:0] vaddr, isr;
  logic [ADDR_W-1:0] isr_seen = '0;
  logic [VEC_W-1:0] num_seen = '0;
  int fails = 0;
  int num_checks = 0;
  int resets = 0;

  initial forever #20 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    if (sreq === 1'b1) resets++;
    if (isr_v === 1'b1) isr_seen <= isr;
    if (take === 1'b1 && irq === 1'b1) num_seen <= vnum;
  end

  vector_irq dut_u (.clock_in(clock_in), .rst_in(rst_in), .por_in(por_in),
    .reg_req_in(req), .read_data_out(rdata), .pending_in(pend),
    .per_source_priority_bits_in(prio), .multi_vector_select_in(mv),
    .single_lock_cycle_fuse_in(fuse), .storage_flash_enable_in(storage_area_flash),
    .take_in(take), .return_in(ret), .entry_valid_in(ev), .entry_data_in(ed),
    .irq_request_out(irq), .irq_high_out(irq_hi), .vector_number_out(vnum),
    .vector_address_out(vaddr), .isr_address_out(isr), .isr_valid_out(isr_v),
    .system_reset_request_out(sreq));

  core_model core_u (.clock_in(clock_in), .rst_in(rst_in), .irq_request_in(irq),
    .multi_in(mv), .entry_in(entry), .take_out(take), .entry_valid_out(ev),
    .entry_data_out(ed));

  task print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock_in);
    req <= '0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_in);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock_in);
    req <= '0;
    // Taken at the edge that closes the data cycle, so later drives stay on edges
    @(posedge clock_in);
    d = rdata;
  endtask : rd

  task rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk

  // Bounded wait: a value that never appears ends the run
  task poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    int i;
    for (i = 0; i < 40; i++) begin
      rd(a, d);
      if ((d & m) === e) break;
    end
    chk(d & m, e);
    if (i == 40) print_verdict();
  endtask : poll

  task pulse_ret();
    @(posedge clock_in);
    ret <= 1'b1;
    @(posedge clock_in);
    ret <= 1'b0;
  endtask : pulse_ret

  // key bytes then the new lock value
  task key(input logic [31:0] v);
    wr(REG_LOCK, 32'h55);
    wr(REG_LOCK, 32'haa);
    wr(REG_LOCK, v);
  endtask : key

  task restart(input logic m, input logic f);
    @(posedge clock_in);
    mv <= m;
    fuse <= f;
    rst_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
  endtask : restart

  initial begin
    restart(1'b0, 1'b0);
    rchk(REG_BASE, 32'h8);
    rchk(REG_CONTROL, 32'h0);
    rchk(REG_LOCK, 32'h0);
    rchk(4'h5, 32'h0);
    rchk(REG_STATUS, 32'h10);
    $display("done: reset values");
    wr(REG_CONTROL, 32'h4);
    pend[3] <= 1'b1;
    poll(REG_STATUS, 32'h3, 32'h2);
    rchk(REG_CAPTURED, 32'h8);
    pend <= '0;
    pulse_ret();
    wr(REG_CONTROL, 32'h7);
    pend[3] <= 1'b1;
    poll(REG_STATUS, 32'h3, 32'h1);
    rchk(REG_CAPTURED, 32'h18);
    prio[9] <= 1'b1;
    pend[9] <= 1'b1;
    poll(REG_STATUS, 32'h3, 32'h3);
    rchk(REG_CAPTURED, 32'h8);
    pend[9] <= 1'b0;
    wr(REG_CONTROL, 32'h5);
    pulse_ret();
    poll(REG_STATUS, 32'h3, 32'h1);
    pulse_ret();
    repeat (4) @(posedge clock_in);
    rchk(REG_STATUS, 32'h10);
    pend <= '0;
    $display("done: single vector levels");
    key(32'h1);
    rchk(REG_LOCK, 32'h0);
    wr(REG_CONTROL, 32'h0);
    key(32'h1);
    wr(REG_BASE, 32'h40);
    rchk(REG_BASE, 32'h8);
    wr(REG_LOCK, 32'h0);
    rchk(REG_LOCK, 32'h1);
    key(32'h0);
    wr(REG_BASE, 32'h40);
    rchk(REG_BASE, 32'h40);
    $display("done: base lock");
    restart(1'b1, 1'b1);
    wr(REG_CONTROL, 32'h7);
    prio[81] <= 1'b1;
    prio[7] <= 1'b1;
    pend[81] <= 1'b1;
    pend[7] <= 1'b1;
    pend[0] <= 1'b1;
    poll(REG_CAPTURED, 32'h1fffff, 32'h16);
    repeat (4) @(posedge clock_in);
    chk(32'(isr_seen), 32'h48d0);
    chk(32'(num_seen), 32'h7);
    pend[7] <= 1'b0;
    pulse_ret();
    poll(REG_CAPTURED, 32'h1fffff, 32'haa);
    chk(32'(num_seen), 32'h51);
    pend[81] <= 1'b0;
    pulse_ret();
    poll(REG_CAPTURED, 32'h1fffff, 32'h8);
    rchk(REG_STATUS, 32'h11);
    pend <= '0;
    pulse_ret();
    wr(REG_CONTROL, 32'h0);
    key(32'h1);
    key(32'h0);
    rchk(REG_LOCK, 32'h1);
    $display("done: multi vector and one-way lock");
    restart(1'b1, 1'b0);
    storage_area_flash <= 1'b1;
    wr(REG_BASE, 32'h01ff00);
    wr(REG_CONTROL, 32'h4);
    pend[0] <= 1'b1;
    poll(REG_STATUS, 32'h10, 32'h0);
    chk(32'(resets), 32'h1);
    pend <= '0;
    restart(1'b1, 1'b0);
    storage_area_flash <= 1'b0;
    wr(REG_STATUS, 32'h10);
    wr(REG_BASE, 32'h01ff00);
    wr(REG_CONTROL, 32'h4);
    pend[0] <= 1'b1;
    poll(REG_STATUS, 32'h3, 32'h2);
    repeat (4) @(posedge clock_in);
    chk(32'(resets), 32'h1);
    entry <= 16'hffff;
    pulse_ret();
    poll(REG_STATUS, 32'h10, 32'h0);
    chk(32'(resets), 32'h2);
    $display("done: fetch checks");
    print_verdict();
  end
endmodule : tb
